// file: src/aei_async_irq_sleep.v
// asynchronous external interrupt, control/status register and sleep clamp
`timescale 1ns/1ps
`include "aei_defines.vh"
module aei_async_irq_sleep
#(
    parameter PIN_COUNT = 8,
    parameter IRQ_PIN = 2
)
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // io register port of the processor
    input wire [6:0] io_addr,
    input wire data_space,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    // processor status
    input wire global_irq_en,
    input wire irq_ack,
    output reg irq_req,
    // pins
    input wire async_ext_irq_pin,
    input wire [PIN_COUNT-1:0] pin_raw,
    input wire [PIN_COUNT-1:0] alt_needs_input,
    input wire [PIN_COUNT-1:0] pullup_cfg,
    output reg [PIN_COUNT-1:0] pin_digital,
    output reg [PIN_COUNT-1:0] pullup_en,
    output reg [PIN_COUNT-1:0] input_buf_en,
    // sleep control
    input wire [2:0] sleep_mode,
    input wire sleep_active,
    // fuses, analog requests and watchdog enable
    input wire debug_enable_fuse,
    input wire test_port_enable_fuse,
    input wire brownout_enable_fuse,
    input wire acomp_ref_req,
    input wire adc_ref_req,
    input wire wdt_enabled,
    // test port data out
    input wire tap_shifting,
    input wire tap_tdo,
    output reg tdo_out,
    output reg tdo_oe,
    // power controls
    output reg main_clk_keep,
    output reg vref_en,
    output reg bod_en,
    output reg wdt_run,
    output reg jtag_en
);
    reg [7:0] mcu_ctrl_status_reg;
    reg irq_mask_reg;
    reg clr_pulse_reg;
    reg [2:0] flag_sync_reg;
    reg flag_stable_reg;
    reg [PIN_COUNT-1:0] pin_s1_reg;
    reg [PIN_COUNT-1:0] pin_s2_reg;
    reg [PIN_COUNT-1:0] pin_s3_reg;
    reg [PIN_COUNT-1:0] pin_stable_reg;
    reg [7:0] rdata_next;

    wire async_irq_flag;
    wire edge_polarity_select = mcu_ctrl_status_reg[`AEI_EDGE_SEL_BIT];
    wire jtag_disable_bit = mcu_ctrl_status_reg[`AEI_JTAG_DIS_BIT];
    // io instructions use the plain offset, loads and stores add the data-space offset
    wire [6:0] eff_addr = data_space ? (io_addr - `AEI_DATA_SPACE_OFS) : io_addr; // see R7
    wire hit_ctrl_status = (eff_addr == {1'b0, `AEI_CTRL_STATUS_ADDR}); // see R7
    wire hit_irq_mask = (eff_addr == {1'b0, `AEI_IRQ_MASK_ADDR});
    wire hit_irq_flag = (eff_addr == {1'b0, `AEI_IRQ_FLAG_ADDR});
    wire flag_clr_wr = io_wr && hit_irq_flag && io_wdata[`AEI_IRQ_BIT]; // see R6
    wire deep_sleep = sleep_active && ((sleep_mode == `AEI_SLEEP_PDOWN) ||
        (sleep_mode == `AEI_SLEEP_PSAVE) || (sleep_mode == `AEI_SLEEP_STANDBY) ||
        (sleep_mode == `AEI_SLEEP_EXTSTBY)); // see R8
    wire pd_or_ps = sleep_active && ((sleep_mode == `AEI_SLEEP_PDOWN) || (sleep_mode == `AEI_SLEEP_PSAVE));
    // io and adc clocks both stop in these same modes
    wire clocks_stopped = deep_sleep; // see R12
    wire irq_enabled_pin = irq_mask_reg;
    wire flag_sync = flag_stable_reg;
    // the clamp on the interrupt pin itself; releasing it makes the edge a high pin needs
    wire irq_clamp = deep_sleep && !irq_enabled_pin && !alt_needs_input[IRQ_PIN]; // see R9 see R10 see R11
    wire pin_clamped_irq = async_ext_irq_pin & ~irq_clamp;

    // clear is a registered pulse so the async cell never sees a combinational glitch
    aei_edge_capture u_capture
    (
        .pin_in(pin_clamped_irq),
        .rising_sel(edge_polarity_select),
        .clr(clr_pulse_reg | ~nrst),
        .flag(async_irq_flag)
    );


    // per pin clamp and buffer enable
    wire [PIN_COUNT-1:0] clamp_vec;
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g = g + 1)
        begin : g_pin
            if (g == IRQ_PIN)
            begin : g_irq
                assign clamp_vec[g] = irq_clamp; // see R9
            end
            else
            begin : g_plain
                assign clamp_vec[g] = deep_sleep && !alt_needs_input[g]; // see R8 see R10
            end
        end
    endgenerate

    // in power-down and power-save the main clock only survives for an enabled debugger
    reg main_clk_keep_next;
    always @*
    begin
        main_clk_keep_next = 1'b1;
        if (pd_or_ps)
        begin
            if (debug_enable_fuse && test_port_enable_fuse && !jtag_disable_bit)
                main_clk_keep_next = 1'b1; // see R13
            else
                main_clk_keep_next = 1'b0; // see R14
        end
    end

    // only the edge select and jtag disable bits are stored; the rest read zero
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mcu_ctrl_status_reg <= `AEI_CTRL_STATUS_RESET;
        end
        else if (io_wr && hit_ctrl_status)
        begin
            mcu_ctrl_status_reg[`AEI_EDGE_SEL_BIT] <= io_wdata[`AEI_EDGE_SEL_BIT]; // see R2
            mcu_ctrl_status_reg[`AEI_JTAG_DIS_BIT] <= io_wdata[`AEI_JTAG_DIS_BIT]; // see R14
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_mask_reg <= 1'b0;
        end
        else if (io_wr && hit_irq_mask)
        begin
            irq_mask_reg <= io_wdata[`AEI_IRQ_BIT]; // see R1
        end
    end

    // hardware vector acknowledge also clears the flag
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clr_pulse_reg <= 1'b0;
        end
        else
        begin
            clr_pulse_reg <= flag_clr_wr | irq_ack; // see R6
        end
    end

    // three stages; stages 2 and 3 must agree before the flag level moves
    // the clear empties the chain, so a stale flag cannot raise the request again
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_sync_reg <= 3'h0;
            flag_stable_reg <= 1'b0;
        end
        else if (clr_pulse_reg)
        begin
            flag_sync_reg <= 3'h0;
            flag_stable_reg <= 1'b0;
        end
        else
        begin
            flag_sync_reg <= {flag_sync_reg[1:0], async_irq_flag}; // see R21
            flag_stable_reg <= (flag_sync_reg[1] & flag_sync_reg[2]) |
                (flag_stable_reg & (flag_sync_reg[1] | flag_sync_reg[2])); // see R21
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_req <= 1'b0;
        end
        else
        begin
            irq_req <= flag_sync && irq_mask_reg && global_irq_en && !clr_pulse_reg; // see R1
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            io_rdata <= 8'h00;
        end
        else
        begin
            io_rdata <= rdata_next; // see R7
        end
    end

    // clamped pins pass five flops; stages 2 and 3 must agree before pin_digital moves
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_reg <= {PIN_COUNT{1'b0}};
            pin_s2_reg <= {PIN_COUNT{1'b0}};
            pin_s3_reg <= {PIN_COUNT{1'b0}};
            pin_stable_reg <= {PIN_COUNT{1'b0}};
            pin_digital <= {PIN_COUNT{1'b0}};
        end
        else
        begin
            pin_s1_reg <= pin_raw & ~clamp_vec; // see R8 see R9
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_stable_reg <= (pin_s2_reg & pin_s3_reg) | (pin_stable_reg & (pin_s2_reg | pin_s3_reg));
            pin_digital <= pin_stable_reg;
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pullup_en <= {PIN_COUNT{1'b0}};
        end
        else
        begin
            pullup_en <= pullup_cfg; // see R20
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            input_buf_en <= {PIN_COUNT{1'b0}};
        end
        else
        begin
            input_buf_en <= clocks_stopped ? ~clamp_vec : {PIN_COUNT{1'b1}}; // see R12
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            jtag_en <= 1'b0;
        end
        else
        begin
            jtag_en <= test_port_enable_fuse && !jtag_disable_bit; // see R14
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            main_clk_keep <= 1'b0;
        end
        else
        begin
            main_clk_keep <= main_clk_keep_next; // see R13
        end
    end

    // the pin floats unless the tap is shifting
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tdo_oe <= 1'b0;
            tdo_out <= 1'b0;
        end
        else
        begin
            tdo_oe <= test_port_enable_fuse && !jtag_disable_bit && tap_shifting; // see R15
            tdo_out <= tap_shifting ? tap_tdo : 1'b0;
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bod_en <= 1'b0;
        end
        else
        begin
            bod_en <= brownout_enable_fuse; // see R18
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vref_en <= 1'b0;
        end
        else
        begin
            vref_en <= brownout_enable_fuse || acomp_ref_req || adc_ref_req; // see R16
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wdt_run <= 1'b0;
        end
        else
        begin
            wdt_run <= wdt_enabled; // see R19
        end
    end

    // unmapped addresses read zero; reserved control bits read zero
    always @*
    begin
        rdata_next = 8'h00;
        if (io_rd && hit_ctrl_status)
            rdata_next = mcu_ctrl_status_reg;
        else if (io_rd && hit_irq_mask)
            rdata_next = {2'b00, irq_mask_reg, 5'h00};
        else if (io_rd && hit_irq_flag)
            rdata_next = {2'b00, flag_sync, 5'h00}; // see R21
    end
endmodule

// file: src/aei_defines.vh
// constants for the asynchronous external interrupt and sleep clamp block
// Overview of operation
// R1 - interrupt needs global enable and mask bit
// R2 - bit 6 selects falling or rising edge
// R3 - pin edges captured without any clock
// R4 - edge select change may set flag
// R5 - software disables, changes edge, clears, re-enables
// R6 - writing one clears the async flag
// R7 - control register at io 0x34, data 0x54
// R8 - clamp inputs in powerdown, powersave, standby
// R9 - clamp bypassed on enabled interrupt pins
// R10 - clamp bypassed for alternate functions needing input
// R11 - high pin sets flag on clamp release
// R12 - input buffers off when io/adc clocks stop
// R13 - debug fuse keeps main clock in sleep
// R14 - jtag disable bit or fuses stop that
// R15 - test data output undriven when not shifting
// R16 - reference on only while requested
// R17 - software waits reference start-up after enable
// R18 - brownout fuse keeps detector on in sleep
// R19 - enabled watchdog runs in all sleep
// R20 - pull-ups disabled during reset
// R21 - async flag synchronised before use
`ifndef AEI_DEFINES_VH
`define AEI_DEFINES_VH
`define AEI_CTRL_STATUS_ADDR 6'h34
`define AEI_DATA_SPACE_OFS 7'h20
`define AEI_CTRL_STATUS_RESET 8'h00
`define AEI_EDGE_SEL_BIT 6
`define AEI_JTAG_DIS_BIT 7
`define AEI_IRQ_MASK_ADDR 6'h3b
`define AEI_IRQ_FLAG_ADDR 6'h3a
`define AEI_IRQ_BIT 5
`define AEI_SLEEP_IDLE 3'h0
`define AEI_SLEEP_ADC 3'h1
`define AEI_SLEEP_PDOWN 3'h2
`define AEI_SLEEP_PSAVE 3'h3
`define AEI_SLEEP_STANDBY 3'h6
`define AEI_SLEEP_EXTSTBY 3'h7
`endif

// file: src/aei_edge_capture.v
// clockless edge capture cell for the asynchronous interrupt pin
`timescale 1ns/1ps
module aei_edge_capture
(
    // pin and selection
    input wire pin_in,
    input wire rising_sel,
    // asynchronous clear, active high
    input wire clr,
    // captured flag
    output reg flag
);
    // the pin itself is the clock; xor turns the selected edge into a rising edge
    wire edge_clk = pin_in ^ ~rising_sel; // see R2 see R3
    // a change of rising_sel toggles edge_clk and can set the flag by itself
    always @(posedge edge_clk or posedge clr) // see R4
    begin
        if (clr)
            flag <= 1'b0;
        else
            flag <= 1'b1;
    end
endmodule

// file: tb/aei_async_irq_sleep_asserts.sv
// assertions on interrupt, register and power outputs
`timescale 1ns/1ps
module aei_chk
#(parameter PIN_COUNT = 8)
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // inputs
    input wire io_rd,
    input wire global_irq_en,
    input wire brownout_enable_fuse,
    input wire acomp_ref_req,
    input wire adc_ref_req,
    input wire wdt_enabled,
    input wire debug_enable_fuse,
    input wire tap_shifting,
    input wire sleep_active,
    input wire [2:0] sleep_mode,
    input wire [PIN_COUNT-1:0] pullup_cfg,
    // outputs
    input wire [7:0] io_rdata,
    input wire irq_req,
    input wire bod_en,
    input wire vref_en,
    input wire wdt_run,
    input wire main_clk_keep,
    input wire tdo_oe,
    input wire [PIN_COUNT-1:0] pullup_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ref_req;
        acomp_ref_req || adc_ref_req || brownout_enable_fuse;
    endsequence
    a_irq_gated: assert property (irq_req |-> $past(global_irq_en)) else $error("irq without enable");
    a_vref_on: assert property (s_ref_req |=> vref_en) else $error("vref off");
    a_vref_off: assert property (!(acomp_ref_req || adc_ref_req || brownout_enable_fuse) |=> !vref_en)
        else $error("vref on");
    a_bod_kept: assert property (brownout_enable_fuse |=> bod_en) else $error("bod off");
    a_wdt_kept: assert property (wdt_enabled |=> wdt_run) else $error("wdt stopped");
    a_clk_nodebug: assert property ((!debug_enable_fuse && sleep_active && (sleep_mode == 3'h2 || sleep_mode == 3'h3))
        |=> !main_clk_keep) else $error("clk kept");
    a_clk_awake: assert property (!sleep_active |=> main_clk_keep) else $error("clk stopped awake");
    a_tdo_float: assert property (!tap_shifting |=> !tdo_oe) else $error("tdo driven");
    a_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00) else $error("rdata not idle");
    a_pullup_copy: assert property ($past(nrst) |-> pullup_en == $past(pullup_cfg)) else $error("pullup");
endmodule

// file: tb/aei_pin_src.sv
// external source driving the asynchronous interrupt pin
`timescale 1ns/1ps
module aei_pin_src
(
    // pin
    output logic pin
);
    initial pin = 1'b0;
    // lands between clock edges, the pin has no clock relation
    task automatic drive(input logic lvl);
        #7 pin = lvl;
    endtask
endmodule

// file: tb/tb_aei_async_irq_sleep.sv
// self-checking bench for the asynchronous interrupt and sleep block
`timescale 1ns/1ps
module tb_aei_async_irq_sleep;
    logic clk = 0, nrst = 0, data_space = 0, io_wr = 0, io_rd = 0, global_irq_en = 0, sleep_active = 0;
    logic debug_enable_fuse = 0, brownout_enable_fuse = 0, wdt_enabled = 0, adc_ref_req = 0, tap_shifting = 0;
    logic [6:0] io_addr = 0;
    logic [7:0] io_wdata = 0, pin_raw = 0, alt_needs_input = 0, pullup_cfg = 8'hff;
    logic [2:0] sleep_mode = 0;
    wire [7:0] io_rdata, pin_digital, pullup_en;
    wire irq_req, async_ext_irq_pin, bod_en, vref_en;
    int err_total = 0, tests_run = 0;
    aei_pin_src src (.pin(async_ext_irq_pin));
    aei_async_irq_sleep dut (.clk, .nrst, .io_addr, .data_space, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .global_irq_en, .irq_ack(1'b0), .irq_req, .async_ext_irq_pin, .pin_raw, .alt_needs_input, .pullup_cfg,
        .pin_digital, .pullup_en, .input_buf_en(), .sleep_mode, .sleep_active, .debug_enable_fuse,
        .test_port_enable_fuse(1'b1), .brownout_enable_fuse, .acomp_ref_req(1'b0), .adc_ref_req, .wdt_enabled,
        .tap_shifting, .tap_tdo(1'b0), .tdo_out(), .tdo_oe(), .main_clk_keep(), .vref_en, .bod_en,
        .wdt_run(), .jtag_en());
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one register cycle; a read expects d back in the following cycle
    task automatic acc(input logic w, input logic [6:0] a, input logic ds, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        data_space <= ds;
        io_wdata <= d;
        io_wr <= w;
        io_rd <= !w;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1 if (!w) chk(io_rdata, d);
    endtask
    task automatic t_regs;
        acc(0, 7'h34, 0, 8'h00);
        acc(1, 7'h34, 0, 8'hff);
        acc(0, 7'h54, 1, 8'hc0);
        acc(0, 7'h10, 0, 8'h00);
        acc(1, 7'h54, 1, 8'h00);
    endtask
    // falling select with global enable off, then rising select with it on
    task automatic t_irq;
        for (int p = 0; p < 2; p++)
        begin
            acc(1, 7'h3b, 0, 8'h00);
            acc(1, 7'h34, 0, p ? 8'h40 : 8'h00);
            src.drive(!p);
            repeat (4) @(posedge clk);
            acc(1, 7'h3a, 0, 8'h20);
            acc(1, 7'h3b, 0, 8'h20);
            @(posedge clk) global_irq_en <= p;
            src.drive(p);
            repeat (7) @(posedge clk);
            #1 chk(irq_req, p);
            acc(0, 7'h3a, 0, 8'h20);
            acc(1, 7'h3a, 0, 8'h20);
            repeat (4) @(posedge clk);
            #1 chk(irq_req, 0);
            acc(0, 7'h3a, 0, 8'h00);
        end
    endtask
    task automatic t_sleep;
        logic [2:0] m[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        @(posedge clk);
        pin_raw <= 8'hff;
        alt_needs_input <= 8'h01;
        sleep_active <= 1'b1;
        foreach (m[i])
        begin
            @(posedge clk) sleep_mode <= m[i];
            repeat (8) @(posedge clk);
            #1 chk(pin_digital, m[i][1] ? 8'h05 : 8'hff);
        end
        acc(1, 7'h3b, 0, 8'h00);
        repeat (8) @(posedge clk);
        #1 chk(pin_digital, 8'h01);
        @(posedge clk) sleep_active <= 1'b0;
        repeat (6) @(posedge clk);
        acc(0, 7'h3a, 0, 8'h20);
        acc(1, 7'h3a, 0, 8'h20);
    endtask
    // walks the debug, brownout, watchdog, adc request and tap shifting combinations watched by the checker
    task automatic t_power;
        sleep_mode <= 3'h2;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk);
            {debug_enable_fuse, brownout_enable_fuse, wdt_enabled, adc_ref_req, tap_shifting} <= i[4:0];
            sleep_active <= i[2];
        end
        @(posedge clk) {debug_enable_fuse, brownout_enable_fuse, wdt_enabled, adc_ref_req, tap_shifting} <= 5'h02;
        // software lets the reference start before it uses the output
        repeat (2) @(posedge clk);
        #1 chk(vref_en, 8'h01);
        @(posedge clk) adc_ref_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(vref_en, 8'h00);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        chk(pullup_en, 8'h00);
        nrst <= 1'b1;
        t_regs;
        t_irq;
        t_sleep;
        t_power;
        tally_and_finish;
    end
endmodule
bind aei_async_irq_sleep aei_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (.clk, .nrst, .io_rd, .io_rdata, .global_irq_en,
    .irq_req, .brownout_enable_fuse, .acomp_ref_req, .adc_ref_req, .wdt_enabled, .debug_enable_fuse,
    .tap_shifting, .sleep_active, .sleep_mode, .pullup_cfg, .bod_en, .vref_en, .wdt_run, .main_clk_keep, .tdo_oe,
    .pullup_en);
